// ==== src/uadt_consts.svh ====
// Purpose: Timing counts, address and field constants for the detector.
// Assumes: A 100 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef UADT_CONSTS_SVH
`define UADT_CONSTS_SVH
`define UADT_CLK_NS 10
`define UADT_SPIKE_NS 50
`define UADT_FILT_CYC (((`UADT_SPIKE_NS)+(`UADT_CLK_NS)-1)/(`UADT_CLK_NS)+1)
`define UADT_MS_NS 1000000
`define UADT_MS_CYC ((`UADT_MS_NS)/(`UADT_CLK_NS))
`define UADT_I2CRST_MS 30
`define UADT_I2CRST_CYC ((`UADT_I2CRST_MS)*((`UADT_MS_NS)/(`UADT_CLK_NS)))
`define UADT_SDP_MS 10'd120
`define UADT_CHG_MS 10'd160
`define UADT_CARKIT_MS 10'd140
`define UADT_DCD_MS 10'd600
`define UADT_ID_CHECK_MS 6'd50
`define UADT_ID_MATCHES 2'd3
`define UADT_SLAVE_ADDR 7'h25
`define UADT_IDLE_LINES 2'h3
`endif

// ==== src/uadt_pkg.sv ====
// Purpose: Types shared by the accessory detect timing block.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are written out in binary.
package uadt_pkg;
    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_AACK = 3'b010,
        I_WR = 3'b011,
        I_WACK = 3'b100,
        I_RD = 3'b101,
        I_RACK = 3'b110
    } uadt_i2c_e;
    typedef enum logic [1:0] {
        ID_FLOAT = 2'b00,
        ID_CHECK = 2'b01,
        ID_ATTACHED = 2'b10
    } uadt_id_e;
    typedef struct packed {
        logic sdp;
        logic cdp;
        logic dcp;
        logic carkit;
    } uadt_det_s;
    typedef struct packed {
        logic fet;
        logic usb;
    } uadt_sw_s;
    typedef struct packed {
        logic scl;
        logic sda;
    } uadt_i2c_s;
endpackage : uadt_pkg

// ==== src/uadt_glitch_filter.sv ====
// Purpose: Synchronise and de-glitch the two serial bus lines.
// Assumes: Lines idle high.
// Notes: A new level is taken only after it has held longer than a spike.
`timescale 1ns/1ps
`include "uadt_consts.svh"
module uadt_glitch_filter (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Raw pins and cleaned levels.
    input wire uadt_pkg::uadt_i2c_s raw,
    output uadt_pkg::uadt_i2c_s clean
);
    import uadt_pkg::*;
    localparam logic [2:0] FILT = 3'(`UADT_FILT_CYC);
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] clean_q;
    logic [1:0] next_clean;
    logic [2:0] cnt [2];
    logic [2:0] next_cnt [2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_cnt[i] = 3'h0;
            next_clean[i] = clean_q[i];
            if (s2[i] != clean_q[i]) begin
                if (cnt[i] == FILT - 3'h1) begin
                    next_clean[i] = s2[i]; // [R8]
                end else begin
                    next_cnt[i] = cnt[i] + 3'h1; // [R8]
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= `UADT_IDLE_LINES;
            s2 <= `UADT_IDLE_LINES;
            clean_q <= `UADT_IDLE_LINES;
            cnt[0] <= 3'h0;
            cnt[1] <= 3'h0;
        end else begin
            s1 <= raw;
            s2 <= s1;
            clean_q <= next_clean;
            cnt[0] <= next_cnt[0];
            cnt[1] <= next_cnt[1];
        end
    end

    assign clean = clean_q;

    chk_spike_reject: assert property (@(posedge clk) disable iff (srst) // [R8]
        $changed(clean_q[0]) |-> $past(cnt[0]) == FILT - 3'h1)
        else $error("data line changed before the spike window passed");
endmodule : uadt_glitch_filter

// ==== src/uadt_top.sv ====
// Purpose: Timing and control core of a port switch with accessory detect.
// Assumes: Detector and control levels arrive as plain inputs.
// Notes: Millisecond timers run off a shared one-millisecond enable.
// How it works
// R1: Serial slave answers only address 0100101; low address bit selects read.
// R2: Both serial lines low for 30 ms resets the device.
// R3: Standard port closes charger switch and data switches 120 ms after power.
// R4: Charging or dedicated port closes charger switch 160 ms after power.
// R5: Car kit charger is reported 140 ms after port power is valid.
// R6: Without port power, ID attach is signalled about 150 ms after leaving float.
// R7: Contact detect phase ends by timeout, nominally 600 ms.
// R8: Spikes up to 50 ns on both serial lines are filtered out.
// R9: Contact timeout only applies while its enable is set.
// R10: Soft reset zero write resets all but the input sync, bus filter and bus-low count; reads back one.
// R11: Automatic mode only closes data switches; never for a dedicated port.
// R12: ID detection uses three consecutive 50 ms checks.
// R13: Millisecond counters derive from the time base and restart on reset.
`timescale 1ns/1ps
`include "uadt_consts.svh"
module uadt_top #(
    parameter int MS_CYC = `UADT_MS_CYC,
    parameter int I2CRST_CYC = `UADT_I2CRST_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Serial bus pins.
    input wire uadt_pkg::uadt_i2c_s i2c_in,
    output logic sda_out,
    output logic sda_oe,
    // Detector levels from the analog side.
    input wire logic port_power_input,
    input wire logic accessory_id_pin,
    input wire logic data_contact,
    input wire uadt_pkg::uadt_det_s port_type,
    // Control levels and soft reset strobe.
    input wire logic manual_switching_enable,
    input wire logic contact_timeout_enable,
    input wire logic soft_reset_write,
    input wire logic soft_reset_bit,
    // Results.
    output uadt_pkg::uadt_sw_s switches,
    output logic carkit_detected,
    output logic accessory_attached,
    output logic dcd_active,
    output logic dcd_timeout,
    output logic device_reset,
    output logic soft_reset_readback,
    output logic [7:0] wr_data,
    output logic wr_valid
);
    import uadt_pkg::*;

    logic rst_int;
    logic [6:0] as1;
    logic [6:0] as2;
    uadt_i2c_s line;
    logic pwr;
    logic id_float;
    logic contact;
    uadt_det_s det;

    assign rst_int = srst | device_reset;
    assign {pwr, id_float, contact, det} = as2;

    // The filter keeps its levels over a device reset, as the sync stage does.
    uadt_glitch_filter u_filter (
        .clk(clk),
        .srst(srst),
        .raw(i2c_in),
        .clean(line)
    );

    // Time base and reset sources.
    logic [16:0] ms_div;
    logic [16:0] next_ms_div;
    logic tick;
    logic [21:0] low_cnt;
    logic [21:0] next_low_cnt;
    logic next_device_reset;

    assign tick = ms_div == 17'(MS_CYC - 1);

    always_comb begin
        next_ms_div = tick ? 17'h0 : ms_div + 17'h1; // [R13]
        next_low_cnt = 22'h0;
        next_device_reset = soft_reset_write & ~soft_reset_bit; // [R10]
        // The count parks one past the limit, so a long hold fires once.
        if (!line.scl && !line.sda) begin
            next_low_cnt = low_cnt;
            if (low_cnt != 22'(I2CRST_CYC)) begin
                next_low_cnt = low_cnt + 22'h1; // [R2]
            end
            if (low_cnt == 22'(I2CRST_CYC - 1)) begin
                next_device_reset = 1'b1; // [R2]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            as1 <= 7'h0;
            as2 <= 7'h0;
            low_cnt <= 22'h0;
            device_reset <= 1'b0;
            soft_reset_readback <= 1'b1;
        end else begin
            as1 <= {port_power_input, accessory_id_pin, data_contact, port_type};
            as2 <= as1;
            low_cnt <= next_low_cnt;
            device_reset <= next_device_reset & ~device_reset;
            soft_reset_readback <= 1'b1; // [R10]
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            ms_div <= 17'h0; // [R13]
        end else begin
            ms_div <= next_ms_div;
        end
    end

    // Power-on switching and contact detect.
    logic [9:0] pwr_ms;
    logic [9:0] next_pwr_ms;
    uadt_sw_s next_switches;
    logic next_carkit;
    logic dcd_done;
    logic next_dcd_done;
    logic next_dcd_timeout;

    always_comb begin
        next_pwr_ms = pwr_ms;
        next_switches = switches;
        next_carkit = carkit_detected;
        next_dcd_done = dcd_done | contact;
        next_dcd_timeout = dcd_timeout;
        if (!pwr) begin
            next_pwr_ms = 10'h0;
            next_switches = '0;
            next_carkit = 1'b0;
            next_dcd_done = 1'b0;
            next_dcd_timeout = 1'b0;
        end else begin
            if (tick && pwr_ms != 10'h3ff) begin
                next_pwr_ms = pwr_ms + 10'h1; // [R13]
            end
            if (det.sdp && pwr_ms >= `UADT_SDP_MS) begin
                next_switches.fet = 1'b1; // [R3]
                if (!manual_switching_enable) begin
                    next_switches.usb = 1'b1; // [R3] [R11]
                end
            end
            if ((det.cdp || det.dcp) && pwr_ms >= `UADT_CHG_MS) begin
                next_switches.fet = 1'b1; // [R4]
                if (det.cdp && !manual_switching_enable) begin
                    next_switches.usb = 1'b1; // [R11]
                end
            end
            if (det.carkit && pwr_ms >= `UADT_CARKIT_MS) begin
                next_carkit = 1'b1; // [R5]
            end
            if (!next_dcd_done && contact_timeout_enable &&
                pwr_ms >= `UADT_DCD_MS) begin
                next_dcd_timeout = 1'b1; // [R7] [R9]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            pwr_ms <= 10'h0;
            switches <= '0;
            carkit_detected <= 1'b0;
            dcd_done <= 1'b0;
            dcd_timeout <= 1'b0;
            dcd_active <= 1'b0;
        end else begin
            pwr_ms <= next_pwr_ms;
            switches <= next_switches;
            carkit_detected <= next_carkit;
            dcd_done <= next_dcd_done;
            dcd_timeout <= next_dcd_timeout;
            dcd_active <= pwr & ~next_dcd_done & ~next_dcd_timeout;
        end
    end

    // Resistor-identified accessory attach.
    uadt_id_e id_st;
    uadt_id_e next_id_st;
    logic [5:0] id_ms;
    logic [5:0] next_id_ms;
    logic [1:0] id_match;
    logic [1:0] next_id_match;

    always_comb begin
        next_id_st = id_st;
        next_id_ms = id_ms;
        next_id_match = id_match;
        case (id_st)
            ID_FLOAT: begin
                next_id_ms = 6'h0;
                next_id_match = 2'h0;
                if (!id_float && !pwr) begin
                    next_id_st = ID_CHECK; // [R6]
                end
            end
            ID_CHECK: begin
                if (id_float) begin
                    next_id_st = ID_FLOAT;
                end else if (tick) begin
                    if (id_ms == `UADT_ID_CHECK_MS - 6'h1) begin
                        next_id_ms = 6'h0; // [R12]
                        next_id_match = id_match + 2'h1;
                        if (id_match == `UADT_ID_MATCHES - 2'h1) begin
                            next_id_st = ID_ATTACHED; // [R6] [R12]
                        end
                    end else begin
                        next_id_ms = id_ms + 6'h1; // [R13]
                    end
                end
            end
            ID_ATTACHED: begin
                if (id_float) begin
                    next_id_st = ID_FLOAT;
                end
            end
            default: begin
                next_id_st = ID_FLOAT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            id_st <= ID_FLOAT;
            id_ms <= 6'h0;
            id_match <= 2'h0;
            accessory_attached <= 1'b0;
        end else begin
            id_st <= next_id_st;
            id_ms <= next_id_ms;
            id_match <= next_id_match;
            accessory_attached <= next_id_st == ID_ATTACHED;
        end
    end

    // Serial slave.
    uadt_i2c_e i2c_st;
    uadt_i2c_e next_i2c_st;
    logic scl_q;
    logic sda_q;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic rw;
    logic next_rw;
    logic addr_full;
    logic next_addr_full;
    logic next_oe;
    logic next_wr_valid;
    logic [7:0] tx;
    logic rise;
    logic fall;

    assign rise = line.scl & ~scl_q;
    assign fall = ~line.scl & scl_q;
    assign tx = {switches, carkit_detected, accessory_attached, dcd_active,
                 dcd_timeout, pwr, 1'b0};

    always_comb begin
        next_i2c_st = i2c_st;
        next_sh = rise ? {sh[6:0], line.sda} : sh;
        next_bit_cnt = bit_cnt;
        next_rw = rw;
        next_addr_full = addr_full;
        next_oe = sda_oe;
        next_wr_valid = 1'b0;
        if (rise && (i2c_st == I_ADDR || i2c_st == I_WR || i2c_st == I_RD)) begin
            next_bit_cnt = bit_cnt + 3'h1;
        end
        // The fall that follows a start must not be taken as the address end.
        if (rise && i2c_st == I_ADDR && bit_cnt == 3'h7) begin
            next_addr_full = 1'b1;
        end
        if (fall) begin
            case (i2c_st)
                I_ADDR: begin
                    if (addr_full) begin
                        next_addr_full = 1'b0;
                        if (sh[7:1] == `UADT_SLAVE_ADDR) begin
                            next_i2c_st = I_AACK; // [R1]
                            next_oe = 1'b1;
                            next_rw = sh[0]; // [R1]
                        end else begin
                            next_i2c_st = I_IDLE; // [R1]
                        end
                    end
                end
                I_AACK: begin
                    next_bit_cnt = 3'h0;
                    next_i2c_st = rw ? I_RD : I_WR;
                    next_oe = rw & ~tx[7];
                end
                I_WR: begin
                    if (bit_cnt == 3'h0) begin
                        next_i2c_st = I_WACK;
                        next_oe = 1'b1;
                        next_wr_valid = 1'b1;
                    end
                end
                I_WACK: begin
                    next_i2c_st = I_WR;
                    next_oe = 1'b0;
                end
                I_RD: begin
                    next_oe = (bit_cnt != 3'h0) & ~tx[3'h7 - bit_cnt];
                    if (bit_cnt == 3'h0) begin
                        next_i2c_st = I_RACK;
                    end
                end
                I_RACK: begin
                    next_i2c_st = sh[0] ? I_IDLE : I_RD;
                    next_oe = ~sh[0] & ~tx[7];
                    next_bit_cnt = 3'h0;
                end
                default: begin
                    next_oe = 1'b0;
                end
            endcase
        end
        if (line.scl && scl_q && sda_q != line.sda) begin
            next_i2c_st = line.sda ? I_IDLE : I_ADDR;
            next_addr_full = 1'b0;
            next_bit_cnt = 3'h0;
            next_oe = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            i2c_st <= I_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sh <= 8'h0;
            bit_cnt <= 3'h0;
            rw <= 1'b0;
            addr_full <= 1'b0;
            sda_oe <= 1'b0;
            wr_valid <= 1'b0;
            wr_data <= 8'h0;
        end else begin
            i2c_st <= next_i2c_st;
            scl_q <= line.scl;
            sda_q <= line.sda;
            sh <= next_sh;
            bit_cnt <= next_bit_cnt;
            rw <= next_rw;
            addr_full <= next_addr_full;
            sda_oe <= next_oe;
            wr_valid <= next_wr_valid;
            wr_data <= next_wr_valid ? sh : wr_data;
        end
    end

    assign sda_out = 1'b0;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_addr_miss;
        i2c_st == I_ADDR && fall && addr_full &&
            sh[7:1] != `UADT_SLAVE_ADDR;
    endsequence
    sequence s_both_low_done;
        !line.scl && !line.sda && low_cnt == 22'(I2CRST_CYC - 1);
    endsequence

    chk_addr_ignore: assert property (s_addr_miss |=> !sda_oe && i2c_st == I_IDLE) // [R1]
        else $error("foreign address was acknowledged");
    chk_low_reset: assert property (s_both_low_done and !device_reset |=> device_reset) // [R2]
        else $error("bus-low reset did not fire");
    chk_sdp_close: assert property (pwr && det.sdp && pwr_ms >= `UADT_SDP_MS && // [R3]
        !manual_switching_enable && !device_reset |=> switches.fet && switches.usb)
        else $error("standard port did not close its switches");
    chk_chg_fet: assert property ($rose(switches.fet) |-> // [R4]
        $past(pwr_ms) >= `UADT_CHG_MS ||
        ($past(det.sdp) && $past(pwr_ms) >= `UADT_SDP_MS))
        else $error("charger switch closed early");
    chk_carkit_time: assert property ($rose(carkit_detected) |-> // [R5]
        $past(pwr_ms) >= `UADT_CARKIT_MS && $past(det.carkit))
        else $error("car kit reported early");
    chk_id_attach: assert property ($rose(accessory_attached) |-> // [R12]
        $past(id_match) == `UADT_ID_MATCHES - 2'h1 && $past(tick))
        else $error("accessory attached without three checks");
    chk_dcd_bound: assert property ($rose(dcd_timeout) |-> // [R7]
        $past(pwr_ms) >= `UADT_DCD_MS && $past(contact_timeout_enable))
        else $error("contact timeout fired early or while disabled");
    chk_dcd_wait: assert property (!contact_timeout_enable && !dcd_timeout && pwr // [R9]
        |=> !dcd_timeout)
        else $error("contact phase timed out while timeout disabled");
    chk_soft_reset: assert property (soft_reset_write && !soft_reset_bit && // [R10]
        !device_reset |=> device_reset ##1 (switches == '0 && soft_reset_readback))
        else $error("soft reset did not clear the device");
    chk_dcp_no_data: assert property ($rose(switches.usb) |-> // [R11]
        !$past(manual_switching_enable) && !($past(det.dcp) && !$past(det.sdp) &&
        !$past(det.cdp)))
        else $error("data switches closed outside automatic mode");
    chk_ms_restart: assert property (device_reset |=> ms_div == 17'h0 && pwr_ms == 10'h0) // [R13]
        else $error("timers did not restart after reset");
endmodule : uadt_top

// ==== tb/uadt_host_model.sv ====
// Purpose: Serial bus host that drives the clock and data lines.
// Assumes: The bench resolves the open-drain data line with a pull-up.
// Notes: Steps of 80 ns; the clock line rests high between frames.
`timescale 1ns/1ps
module uadt_host_model (
    // Bus lines.
    output logic scl,
    output logic sda_drv,
    input wire logic sda_bus
);
    localparam int QTR = 80;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic start_cond;
        sda_drv = 1'b0;
        #(QTR) scl = 1'b0;
        #(QTR);
    endtask : start_cond

    task automatic stop_cond;
        sda_drv = 1'b0;
        #(QTR) scl = 1'b1;
        #(QTR) sda_drv = 1'b1;
        #(QTR);
    endtask : stop_cond

    // A glitch is a 40 ns low spike midway through the clock's high phase.
    task automatic put_bit(input logic b, input logic glitch,
                           output logic seen);
        sda_drv = b;
        #(QTR) scl = 1'b1;
        #(QTR) seen = sda_bus;
        if (glitch) begin
            scl = 1'b0;
            #40 scl = 1'b1;
        end
        #(QTR) scl = 1'b0;
        #(QTR);
    endtask : put_bit

    task automatic send_byte(input logic [7:0] b, input logic glitch,
                             output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], glitch && i == 4, s);
        put_bit(1'b1, 1'b0, s);
        ack = ~s;
    endtask : send_byte

    task automatic recv_byte(input logic nak, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(1'b1, 1'b0, b[i]);
        put_bit(nak, 1'b0, s);
    endtask : recv_byte

    // Holding both lines low for a long span asks the device to reset.
    task automatic hold_low(input int ns);
        sda_drv = 1'b0;
        #(QTR) scl = 1'b0;
        #(ns) scl = 1'b1;
        #(QTR) sda_drv = 1'b1;
        #(QTR);
    endtask : hold_low
endmodule : uadt_host_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the accessory detect timing core.
// Assumes: Millisecond and bus-low counts shortened by parameters.
// Notes: Written bytes are queued and checked by a separate monitor.
`timescale 1ns/1ps
module testbench;
    import uadt_pkg::*;
    localparam int MS = 20;
    localparam int RSTC = 200;
    localparam logic [7:0] BAD [4] = '{8'h4c, 8'h48, 8'hca, 8'hda};
    localparam logic [3:0] PT_T [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8};
    localparam logic MAN_T [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    localparam int LO_T [5] = '{118, 158, 158, 138, 118};
    localparam int HI_T [5] = '{122, 162, 162, 142, 122};
    localparam logic [7:0] MASK_T [5] = '{8'hc0, 8'hc0, 8'hc0, 8'h20, 8'hc0};
    localparam logic [7:0] WANT_T [5] = '{8'hc0, 8'hc0, 8'h80, 8'h20, 8'h80};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic h_scl, h_sda, sda_out, sda_oe, sda_bus;
    uadt_i2c_s pins;
    logic pwr = 1'b0;
    logic id_pin = 1'b1;
    uadt_det_s ptype = '0;
    logic man = 1'b0;
    logic tmo_en = 1'b1;
    logic contact = 1'b0;
    logic sr_wr = 1'b0;
    logic sr_bit = 1'b1;
    uadt_sw_s sw;
    logic carkit, attached, dcd_act, dcd_tmo, dev_rst, sr_rb, wr_valid;
    logic [7:0] wr_data;
    int errors = 0;
    int total_checks = 0;
    int cnt = 0;
    int t0 = 0;
    int rst_seen = 0;
    logic [7:0] exp_q [$];

    always #5 clk = ~clk;
    assign sda_bus = h_sda & ~(sda_oe & ~sda_out);
    assign pins = '{scl: h_scl, sda: sda_bus};

    uadt_host_model host (.scl(h_scl), .sda_drv(h_sda), .sda_bus(sda_bus));

    uadt_top #(.MS_CYC(MS), .I2CRST_CYC(RSTC)) dut (
        .clk(clk), .srst(srst), .i2c_in(pins), .sda_out(sda_out),
        .sda_oe(sda_oe), .port_power_input(pwr), .accessory_id_pin(id_pin),
        .data_contact(contact), .port_type(ptype),
        .manual_switching_enable(man), .contact_timeout_enable(tmo_en),
        .soft_reset_write(sr_wr), .soft_reset_bit(sr_bit), .switches(sw),
        .carkit_detected(carkit), .accessory_attached(attached),
        .dcd_active(dcd_act), .dcd_timeout(dcd_tmo), .device_reset(dev_rst),
        .soft_reset_readback(sr_rb), .wr_data(wr_data), .wr_valid(wr_valid)
    );

    always @(posedge clk) begin
        cnt <= cnt + 1;
        if (dev_rst === 1'b1)
            rst_seen <= rst_seen + 1;
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Each written byte must match the oldest queued expectation.
    always @(negedge clk) begin
        if (wr_valid === 1'b1) begin
            check("byte expected", 8'h01, {7'h0, exp_q.size() != 0});
            if (exp_q.size() != 0)
                check("written byte", exp_q.pop_front(), wr_data);
        end
    end

    function automatic logic [7:0] stat();
        return {sw.fet, sw.usb, carkit, attached, dcd_act, dcd_tmo, 2'b00};
    endfunction : stat

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic expect_at(input string what, input int ms,
                             input logic [7:0] mask, input logic [7:0] want);
        while (cnt < t0 + ms * MS)
            @(negedge clk);
        check(what, want, stat() & mask);
    endtask : expect_at

    task automatic power_up(input uadt_det_s t);
        @(negedge clk);
        ptype = t;
        pwr = 1'b1;
        t0 = cnt;
    endtask : power_up

    task automatic power_down;
        @(negedge clk);
        pwr = 1'b0;
        ptype = '0;
        cyc(4);
        check("power drop clears", 8'h00, stat());
    endtask : power_down

    task automatic pulse_soft(input logic b);
        @(negedge clk);
        sr_wr = 1'b1;
        sr_bit = b;
        @(negedge clk);
        sr_wr = 1'b0;
        sr_bit = 1'b1;
        cyc(3);
    endtask : pulse_soft

    task automatic bus_write(input logic [7:0] adr, input logic glitch,
                             input logic want);
        logic ack;
        logic [7:0] b;
        host.start_cond();
        host.send_byte(adr, glitch, ack);
        check("address ack", {7'h0, want}, {7'h0, ack});
        for (int i = 0; i < 2 && want; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            host.send_byte(b, glitch, ack);
            check("data ack", 8'h01, {7'h0, ack});
        end
        host.stop_cond();
    endtask : bus_write

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        #900_000;
        errors++;
        tally_and_finish();
    end

    initial begin
        int seed;
        int r;
        logic ack;
        logic [7:0] d;
        seed = $urandom(81308);
        repeat (8) @(negedge clk);
        srst = 1'b0;
        cyc(2);
        check("readback", 8'h01, {7'h0, sr_rb});
        check("idle state", 8'h00, stat());
        bus_write(8'h4a, 1'b0, 1'b1);
        bus_write(8'h4a, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++)
            bus_write(BAD[i], 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            man = MAN_T[i];
            power_up(PT_T[i]);
            expect_at("early", LO_T[i], MASK_T[i], 8'h00);
            expect_at("closed", HI_T[i], MASK_T[i], WANT_T[i]);
            power_down();
        end
        man = 1'b0;
        power_up('0);
        expect_at("contact early", 598, 8'h04, 8'h00);
        expect_at("contact timeout", 602, 8'h04, 8'h04);
        power_down();
        tmo_en = 1'b0;
        power_up('0);
        expect_at("timeout disabled", 602, 8'h04, 8'h00);
        tmo_en = 1'b1;
        cyc(4);
        check("late enable", 8'h04, stat() & 8'h04);
        power_down();
        power_up('0);
        contact = 1'b1;
        expect_at("contact seen", 602, 8'h0c, 8'h00);
        power_down();
        contact = 1'b0;
        @(negedge clk);
        id_pin = 1'b0;
        t0 = cnt;
        expect_at("id early", 148, 8'h10, 8'h00);
        expect_at("id attach", 152, 8'h10, 8'h10);
        id_pin = 1'b1;
        cyc(4);
        check("id float", 8'h00, stat() & 8'h10);
        power_up(4'h8);
        expect_at("sdp closed", 122, 8'hc0, 8'hc0);
        host.start_cond();
        host.send_byte(8'h4b, 1'b0, ack);
        host.recv_byte(1'b1, d);
        host.stop_cond();
        check("read ack", 8'h01, {7'h0, ack});
        check("read byte", 8'hc2, d & 8'hc3);
        r = rst_seen;
        pulse_soft(1'b1);
        check("bit one ignored", 8'hc0, stat() & 8'hc0);
        pulse_soft(1'b0);
        t0 = cnt;
        // Port power still stands, so the contact phase starts over.
        check("soft reset", 8'h08, stat());
        check("reset pulse", 8'(r + 1), 8'(rst_seen));
        check("reads back one", 8'h01, {7'h0, sr_rb});
        expect_at("restart early", 118, 8'hc0, 8'h00);
        expect_at("restart", 122, 8'hc0, 8'hc0);
        power_down();
        r = rst_seen;
        host.hold_low(RSTC * 10 - 300);
        cyc(20);
        check("short low", 8'(r), 8'(rst_seen));
        host.hold_low(RSTC * 10 + 400);
        cyc(20);
        check("bus low reset", 8'(r + 1), 8'(rst_seen));
        check("queue empty", 8'h00, 8'(exp_q.size()));
        tally_and_finish();
    end
endmodule : testbench
